// >>> core/pwm_fault_pkg.sv
// Constants for the PWM fault protection and enable block
package pwm_fault_pkg;
    localparam int unsigned ADDR_W     = 4;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned NUM_FAULTS = 4;
    localparam int unsigned NUM_PWM    = 6;
    // Register offsets
    localparam logic [3:0] OFS_CTRL    = 4'h0;
    localparam logic [3:0] OFS_FCTRL   = 4'h1;
    localparam logic [3:0] OFS_FSTAT   = 4'h2;
    localparam logic [3:0] OFS_FACK    = 4'h3;
    localparam logic [3:0] OFS_DIRECT_OUTPUT_CTRL  = 4'h4;
    localparam logic [3:0] OFS_MAPX    = 4'h5;
    localparam logic [3:0] OFS_MAPY    = 4'h6;
    localparam logic [3:0] OFS_POL     = 4'h7;
    // Control register fields
    localparam int unsigned CTRL_EN    = 0;
    localparam int unsigned CTRL_LOAD_OK  = 1;
    localparam int unsigned CTRL_RFLAG = 2;
    localparam int unsigned CTRL_RIE   = 3;
    localparam int unsigned CTRL_SDX   = 4;
    localparam int unsigned CTRL_SDY   = 5;
    // Fault control fields: irq enables low, auto mode high
    localparam int unsigned FCTRL_IE   = 0;
    localparam int unsigned FCTRL_AUTO = 4;
    // Output control fields
    localparam int unsigned OUT_DIRECT = 6;
    // Polarity fields
    localparam int unsigned POL_TOP    = 0;
    localparam int unsigned POL_BOT    = 1;
    // Reset values
    localparam logic [5:0] MAP_RESET   = 6'h3f;
    localparam logic [7:0] ZERO_BYTE   = 8'h00;
endpackage

// >>> core/fault_filter.sv
// Fault input synchroniser and glitch filter, one input
`timescale 1ns/100ps
`default_nettype none
module fault_filter
(
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_fault,
    output logic      o_state,
    output logic      o_rise,
    output logic      o_low_now
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic hist1;
        logic hist2;
        logic state;
        logic rise;
    } filt_type;

    filt_type s_q;
    filt_type s_d;

    always_comb
    begin
        s_d       = s_q;
        s_d.sync1 = i_fault;
        s_d.sync2 = s_q.sync1;
        s_d.hist1 = s_q.sync2;
        s_d.hist2 = s_q.hist1;
        s_d.rise  = 1'b0;
        if (!s_q.state && !s_q.hist2 && s_q.hist1 && s_q.sync2)
        begin
            s_d.state = 1'b1;
            s_d.rise  = 1'b1;
        end
        else if (s_q.state && !s_q.sync2)
        begin
            s_d.state = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign o_state   = s_q.state;
    assign o_rise    = s_q.rise;
    assign o_low_now = !s_q.sync2;
endmodule
`default_nettype wire

// >>> core/pwm_fault_disable_enable.sv
// Fault disable, software disable and enable control for six PWM pins
// Summary of operation
// - Any fault or soft disable forces mapped pins inactive; generator runs on.
// - Faults 1,2 and soft X form bank X; faults 3,4 and soft Y bank Y.
// - Write-once maps choose pins per bank; all set disables every pin.
// - Each fault input has its own interrupt request line.
// - Per fault mode bit: set means automatic, clear means manual re-enable.
// - After one low cycle, two consecutive high samples set state and flag.
// - Filtered state holds until sampled low; software writes are ignored.
// - Automatic: disable at once, re-enable when low at cycle start.
// - Event flag sets on filtered rise, clears only by writing 1 to ack.
// - Enabled flag set latches irq; ack, enable clear or reset clear it.
// - Latch cleared early means no request; fetch changes nothing.
// - Manual: stay disabled until acknowledged and a new cycle begins.
// - Manual faults 1 and 3 re-enable at cycle start whatever the level.
// - Manual faults 2 and 4 re-enable only if input low at cycle start.
// - Soft disable acts at once, ends at cycle start; no flag, no irq.
// - Direct output control keeps protection; clearing tick is every cycle.
// - First enable reloads at once, sets reload flag, may raise irq.
// - Generator loads values only when load-ok is set at reload.
// - Dead-time stays in the generator; this block never shortens it.
// - Enable turns pins from floating to driven, following the generator.
// - Enable clear floats pins unless direct, stops counter, zeroes the source before polarity.
// - With enable clear, faults and direct control stay active, flags kept.
// - Direct control makes override bits drive the pins.
// - Pins 1,3,5 top, 2,4,6 bottom, each group with its own polarity.
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module pwm_fault_disable_enable
    import pwm_fault_pkg::*;
(
    input  wire logic                            i_clk,
    input  wire logic                            i_resetn,
    input  wire logic [pwm_fault_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [pwm_fault_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                            i_wr,
    input  wire logic                            i_rd,
    input  wire logic [pwm_fault_pkg::NUM_FAULTS-1:0] i_fault,
    input  wire logic [pwm_fault_pkg::NUM_PWM-1:0] i_gen_out,
    input  wire logic                            i_cycle_start,
    output logic [pwm_fault_pkg::DATA_W-1:0]     o_rdata,
    output logic [pwm_fault_pkg::NUM_PWM-1:0]    o_pwm,
    output logic [pwm_fault_pkg::NUM_PWM-1:0]    o_pwm_oe_n,
    output logic [pwm_fault_pkg::NUM_FAULTS-1:0] o_fault_irq,
    output logic                                 o_reload_irq,
    output logic                                 o_counter_run,
    output logic                                 o_load_values,
    output logic                                 o_first_reload
);
    import pwm_fault_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0]     rdata;
        logic                  module_enable;
        logic                  load_ok;
        logic                  reload_flag;
        logic                  reload_irq_enable;
        logic                  soft_disable_bank_x;
        logic                  soft_disable_bank_y;
        logic [NUM_FAULTS-1:0] fault_irq_enable;
        logic [NUM_FAULTS-1:0] fault_reenable_auto;
        logic [NUM_FAULTS-1:0] fault_event_flag;
        logic [NUM_FAULTS-1:0] irq_latch;
        logic [NUM_FAULTS-1:0] fault_hold;
        logic                  soft_hold_x;
        logic                  soft_hold_y;
        logic [NUM_PWM-1:0]    output_override_bits;
        logic                  direct_output_ctrl;
        logic [NUM_PWM-1:0]    map_x;
        logic [NUM_PWM-1:0]    map_y;
        logic                  map_x_locked;
        logic                  map_y_locked;
        logic                  top_neg;
        logic                  bot_neg;
        logic [NUM_PWM-1:0]    pwm;
        logic [NUM_PWM-1:0]    pwm_oe_n;
        logic                  load_values;
        logic                  first_reload;
    } state_type;

    state_type s_q;
    state_type s_d;

    logic [NUM_FAULTS-1:0] fault_state;
    logic [NUM_FAULTS-1:0] fault_rise;
    logic [NUM_FAULTS-1:0] fault_low;
    logic [NUM_FAULTS-1:0] fault_dis;
    logic [NUM_FAULTS-1:0] ack;
    logic                  bank_x;
    logic                  bank_y;
    logic                  clear_tick;
    logic                  reload_evt;
    logic [NUM_PWM-1:0]    dis_mask;
    logic [NUM_PWM-1:0]    neg_mask;
    logic [NUM_PWM-1:0]    src;
    logic                  wr_ctrl;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FAULTS; gi++)
        begin : g_filt
            fault_filter u_filt
            (
                .i_clk     (i_clk),
                .i_resetn  (i_resetn),
                .i_fault   (i_fault[gi]),
                .o_state   (fault_state[gi]),
                .o_rise    (fault_rise[gi]),
                .o_low_now (fault_low[gi])
            );
            assign fault_dis[gi] = s_q.fault_hold[gi] | fault_rise[gi]
                | (s_q.fault_reenable_auto[gi] & fault_state[gi]);
        end
    endgenerate

    assign wr_ctrl    = i_wr && (i_addr == OFS_CTRL);
    assign ack        = (i_wr && i_addr == OFS_FACK) ?
                        i_wdata[NUM_FAULTS-1:0] : '0;
    // every cycle counts as a cycle start under direct control
    assign clear_tick = i_cycle_start | s_q.direct_output_ctrl;
    assign bank_x = fault_dis[0] | fault_dis[1] | s_q.soft_hold_x
                  | s_q.soft_disable_bank_x;
    assign bank_y = fault_dis[2] | fault_dis[3] | s_q.soft_hold_y
                  | s_q.soft_disable_bank_y;
    assign dis_mask = ({NUM_PWM{bank_x}} & s_q.map_x)
                    | ({NUM_PWM{bank_y}} & s_q.map_y);
    // top on even index, bottom on odd index
    assign neg_mask = {3{s_q.bot_neg, s_q.top_neg}};
    assign reload_evt = (i_cycle_start && s_q.module_enable)
                     || (wr_ctrl && i_wdata[CTRL_EN] && !s_q.module_enable);

    always_comb
    begin
        s_d              = s_q;
        s_d.load_values  = 1'b0;
        s_d.first_reload = 1'b0;
        src              = '0;

        // Register writes
        if (wr_ctrl)
        begin
            s_d.module_enable       = i_wdata[CTRL_EN];
            s_d.load_ok             = i_wdata[CTRL_LOAD_OK];
            s_d.reload_irq_enable   = i_wdata[CTRL_RIE];
            s_d.soft_disable_bank_x = i_wdata[CTRL_SDX];
            s_d.soft_disable_bank_y = i_wdata[CTRL_SDY];
            if (!i_wdata[CTRL_RFLAG])
                s_d.reload_flag = 1'b0;
        end
        if (i_wr && i_addr == OFS_FCTRL)
        begin
            s_d.fault_irq_enable    = i_wdata[FCTRL_IE +: NUM_FAULTS];
            s_d.fault_reenable_auto = i_wdata[FCTRL_AUTO +: NUM_FAULTS];
        end
        if (i_wr && i_addr == OFS_DIRECT_OUTPUT_CTRL)
        begin
            s_d.output_override_bits = i_wdata[NUM_PWM-1:0];
            s_d.direct_output_ctrl   = i_wdata[OUT_DIRECT];
        end
        if (i_wr && i_addr == OFS_MAPX && !s_q.map_x_locked)
        begin
            s_d.map_x        = i_wdata[NUM_PWM-1:0];
            s_d.map_x_locked = 1'b1;
        end
        if (i_wr && i_addr == OFS_MAPY && !s_q.map_y_locked)
        begin
            s_d.map_y        = i_wdata[NUM_PWM-1:0];
            s_d.map_y_locked = 1'b1;
        end
        if (i_wr && i_addr == OFS_POL)
        begin
            s_d.top_neg = i_wdata[POL_TOP];
            s_d.bot_neg = i_wdata[POL_BOT];
        end

        // reload sets flag, set wins over clear
        if (reload_evt)
        begin
            s_d.reload_flag  = 1'b1;
            s_d.first_reload = !s_q.module_enable;
            s_d.load_values  = s_q.load_ok;
            s_d.load_ok      = 1'b0;
        end

        for (int i = 0; i < NUM_FAULTS; i++)
        begin
            if (ack[i])
                s_d.fault_event_flag[i] = 1'b0;
            if (fault_rise[i])
                s_d.fault_event_flag[i] = 1'b1;
            // latch clear on ack or enable clear
            if (ack[i] || !s_d.fault_irq_enable[i])
                s_d.irq_latch[i] = 1'b0;
            if (fault_rise[i] && s_d.fault_irq_enable[i])
                s_d.irq_latch[i] = 1'b1;
            if (fault_rise[i])
                s_d.fault_hold[i] = 1'b1;
            else if (clear_tick && s_q.fault_hold[i])
            begin
                if (s_q.fault_reenable_auto[i])
                begin
                    if (!fault_state[i])
                        s_d.fault_hold[i] = 1'b0;
                end
                else if (!s_q.fault_event_flag[i])
                begin
                    if (i % 2 == 0)
                        s_d.fault_hold[i] = 1'b0;
                    // even inputs need a low level
                    else if (fault_low[i])
                        s_d.fault_hold[i] = 1'b0;
                end
            end
        end

        // soft disable held until cycle start
        if (s_q.soft_disable_bank_x)
            s_d.soft_hold_x = 1'b1;
        else if (clear_tick)
            s_d.soft_hold_x = 1'b0;
        if (s_q.soft_disable_bank_y)
            s_d.soft_hold_y = 1'b1;
        else if (clear_tick)
            s_d.soft_hold_y = 1'b0;

        if (s_q.direct_output_ctrl)
            src = s_q.output_override_bits;
        // generator forced to zero when disabled
        else if (s_q.module_enable)
            src = i_gen_out;
        s_d.pwm = (src & ~dis_mask) ^ neg_mask;
        s_d.pwm_oe_n = {NUM_PWM{!(s_q.module_enable
                                  || s_q.direct_output_ctrl)}};

        // Read data, one cycle after the strobe
        s_d.rdata = ZERO_BYTE;
        if (i_rd)
        begin
            unique case (i_addr)
                OFS_CTRL:
                    s_d.rdata = {2'b00, s_q.soft_disable_bank_y,
                                 s_q.soft_disable_bank_x,
                                 s_q.reload_irq_enable, s_q.reload_flag,
                                 s_q.load_ok, s_q.module_enable};
                OFS_FCTRL:
                    s_d.rdata = {s_q.fault_reenable_auto,
                                 s_q.fault_irq_enable};
                OFS_FSTAT:
                    s_d.rdata = {s_q.fault_event_flag, fault_state};
                OFS_DIRECT_OUTPUT_CTRL:
                    s_d.rdata = {1'b0, s_q.direct_output_ctrl,
                                 s_q.output_override_bits};
                OFS_MAPX:
                    s_d.rdata = {2'b00, s_q.map_x};
                OFS_MAPY:
                    s_d.rdata = {2'b00, s_q.map_y};
                OFS_POL:
                    s_d.rdata = {6'h00, s_q.bot_neg, s_q.top_neg};
                default:
                    s_d.rdata = ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            s_q          <= '0;
            s_q.map_x    <= MAP_RESET;
            s_q.map_y    <= MAP_RESET;
            s_q.pwm_oe_n <= '1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_rdata        = s_q.rdata;
    assign o_pwm          = s_q.pwm;
    assign o_pwm_oe_n     = s_q.pwm_oe_n;
    assign o_fault_irq    = s_q.irq_latch;
    assign o_reload_irq   = s_q.reload_flag & s_q.reload_irq_enable;
    // dead-time untouched, counter held while off
    assign o_counter_run  = s_q.module_enable;
    assign o_load_values  = s_q.load_values;
    assign o_first_reload = s_q.first_reload;

    // Assertions
    property p_rise_sets_flag;
        @(posedge i_clk) disable iff (!i_resetn)
        fault_rise[0] |=> s_q.fault_event_flag[0];
    endproperty
    a_rise_sets_flag: assert property (p_rise_sets_flag)
        else $error("flag not set by filtered rise");

    property p_ack_clears;
        @(posedge i_clk) disable iff (!i_resetn)
        (ack[1] && !fault_rise[1]) |=> !s_q.fault_event_flag[1]
            && !s_q.irq_latch[1];
    endproperty
    a_ack_clears: assert property (p_ack_clears)
        else $error("ack did not clear flag and latch");

    property p_irq_needs_enable;
        @(posedge i_clk) disable iff (!i_resetn)
        o_fault_irq[2] |-> s_q.fault_irq_enable[2];
    endproperty
    a_irq_needs_enable: assert property (p_irq_needs_enable)
        else $error("fault irq without enable");

    property p_fault_forces_inactive;
        @(posedge i_clk) disable iff (!i_resetn)
        (fault_rise[0] && s_q.map_x[0]) |=> o_pwm[0] == s_q.top_neg;
    endproperty
    a_fault_forces_inactive: assert property (p_fault_forces_inactive)
        else $error("mapped pin not forced inactive");

    property p_soft_no_flag;
        @(posedge i_clk) disable iff (!i_resetn)
        (s_q.soft_disable_bank_y && !fault_rise[3]) |=>
            !$rose(s_q.fault_event_flag[3]);
    endproperty
    a_soft_no_flag: assert property (p_soft_no_flag)
        else $error("soft disable raised a flag");

    property p_hold_until_tick;
        @(posedge i_clk) disable iff (!i_resetn)
        ($fell(s_q.fault_hold[1])) |-> $past(clear_tick);
    endproperty
    a_hold_until_tick: assert property (p_hold_until_tick)
        else $error("fault released without cycle start");

    property p_even_needs_low;
        @(posedge i_clk) disable iff (!i_resetn)
        ($fell(s_q.fault_hold[1]) && !$past(s_q.fault_reenable_auto[1]))
            |-> $past(fault_low[1]);
    endproperty
    a_even_needs_low: assert property (p_even_needs_low)
        else $error("manual fault 2 released while high");

    property p_float_when_off;
        @(posedge i_clk) disable iff (!i_resetn)
        (!s_q.module_enable && !s_q.direct_output_ctrl) ##1
            (!s_q.module_enable && !s_q.direct_output_ctrl)
            |-> o_pwm_oe_n == '1;
    endproperty
    a_float_when_off: assert property (p_float_when_off)
        else $error("pins driven while disabled");

    property p_first_enable_reload;
        @(posedge i_clk) disable iff (!i_resetn)
        (wr_ctrl && i_wdata[CTRL_EN] && !s_q.module_enable)
            |=> s_q.reload_flag && s_q.first_reload;
    endproperty
    a_first_enable_reload: assert property (p_first_enable_reload)
        else $error("no reload on first enable");

    c_fault_irq: cover property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(o_fault_irq[0]));
    c_manual_release: cover property (@(posedge i_clk)
        disable iff (!i_resetn) $fell(s_q.fault_hold[1]));
    c_direct_ctrl: cover property (@(posedge i_clk) disable iff (!i_resetn)
        s_q.direct_output_ctrl && bank_x);
endmodule
`default_nettype wire

// >>> test/fault_drive_model.sv
// Drive-side fault source: holds each fault line high for a set count of cycles, or until told otherwise with length ff
`timescale 1ns/100ps
`default_nettype none
module fault_drive_model
(
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_go,
    input  wire logic [1:0] i_idx,
    input  wire logic [7:0] i_len,
    output logic      [3:0] o_fault
);
    logic [7:0] cnt_q [4];

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            for (int i = 0; i < 4; i++)
                cnt_q[i] <= 8'h00;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                // Length ff holds the line until told otherwise
                if (i_go && i_idx == i[1:0])
                    cnt_q[i] <= i_len;
                else if (cnt_q[i] != 8'h00 && cnt_q[i] != 8'hff)
                    cnt_q[i] <= cnt_q[i] - 8'h01;
            end
        end
    end

    always_comb
    begin
        for (int i = 0; i < 4; i++)
            o_fault[i] = (cnt_q[i] != 8'h00);
    end
endmodule
`default_nettype wire

// >>> test/pwm_fault_disable_enable_tb_top.sv
// Testbench for the PWM fault disable and enable block
`timescale 1ns/100ps
`default_nettype none
module pwm_fault_disable_enable_tb_top
    import pwm_fault_pkg::*;
;
    logic                  clk;
    logic                  resetn;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     wdata;
    logic                  wr_s;
    logic                  rd_s;
    logic [NUM_PWM-1:0]    gen;
    logic                  cyc;
    logic                  go;
    logic [1:0]            idx;
    logic [7:0]            len;
    logic [NUM_FAULTS-1:0] fault;
    logic [DATA_W-1:0]     rdata;
    logic [NUM_PWM-1:0]    pwm;
    logic [NUM_PWM-1:0]    oe_n;
    logic [NUM_FAULTS-1:0] firq;
    logic                  rirq;
    logic                  run;
    logic                  first_p;
    logic                  load_p;
    int                    first_cnt = 0;
    int                    load_cnt = 0;
    int                    error_cnt;
    int                    total_checks;

    pwm_fault_disable_enable dut
    (
        .i_clk          (clk),
        .i_resetn       (resetn),
        .i_addr         (addr),
        .i_wdata        (wdata),
        .i_wr           (wr_s),
        .i_rd           (rd_s),
        .i_fault        (fault),
        .i_gen_out      (gen),
        .i_cycle_start  (cyc),
        .o_rdata        (rdata),
        .o_pwm          (pwm),
        .o_pwm_oe_n     (oe_n),
        .o_fault_irq    (firq),
        .o_reload_irq   (rirq),
        .o_counter_run  (run),
        .o_load_values  (load_p),
        .o_first_reload (first_p)
    );

    // Counts the one-cycle reload pulses
    always @(posedge clk)
    begin
        if (first_p === 1'b1)
            first_cnt <= first_cnt + 1;
        if (load_p === 1'b1)
            load_cnt <= load_cnt + 1;
    end

    fault_drive_model drive
    (
        .i_clk    (clk),
        .i_resetn (resetn),
        .i_go     (go),
        .i_idx    (idx),
        .i_len    (len),
        .o_fault  (fault)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        check(rdata, e);
    endtask

    task automatic raise(input logic [1:0] i, input logic [7:0] n);
        @(posedge clk);
        go <= 1'b1;
        idx <= i;
        len <= n;
        @(posedge clk);
        go <= 1'b0;
    endtask

    task automatic start_cycle();
        @(posedge clk);
        cyc <= 1'b1;
        @(posedge clk);
        cyc <= 1'b0;
    endtask

    // Waits for the mask to settle, then compares the pins
    task automatic pins(input logic [5:0] e);
        tick(3);
        check({2'b00, pwm}, {2'b00, e});
    endtask

    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end

    initial
    begin
        {addr, wdata, wr_s, rd_s, cyc, go, idx, len} = '0;
        gen = 6'h3f;
        resetn = 1'b0;
        error_cnt = 0;
        total_checks = 0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rd(OFS_MAPX, 8'h3f);
        wr(OFS_MAPX, 8'h03);
        wr(OFS_MAPX, 8'h3f);
        rd(OFS_MAPX, 8'h03);
        wr(OFS_MAPY, 8'h30);
        check({2'b00, oe_n}, 8'h3f);
        wr(OFS_CTRL, 8'h09);
        tick(3);
        check({2'b00, oe_n}, 8'h00);
        check({7'h00, rirq}, 8'h01);
        check({7'h00, run}, 8'h01);
        check(first_cnt[7:0], 8'h01);
        check(load_cnt[7:0], 8'h00);
        rd(OFS_CTRL, 8'h0d);
        wr(OFS_CTRL, 8'h0f);
        start_cycle();
        tick(1);
        check(load_cnt[7:0], 8'h01);
        rd(OFS_CTRL, 8'h0d);
        rd(4'hf, 8'h00);
        @(posedge clk) gen <= 6'h2a;
        pins(6'h2a);
        @(posedge clk) gen <= 6'h3f;
        wr(OFS_FCTRL, 8'h0f);
        raise(2'd0, 8'h01);
        tick(8);
        rd(OFS_FSTAT, 8'h00);
        raise(2'd0, 8'hff);
        tick(6);
        check({4'h0, firq}, 8'h01);
        pins(6'h3c);
        wr(OFS_FSTAT, 8'h00);
        rd(OFS_FSTAT, 8'h11);
        raise(2'd0, 8'h00);
        tick(6);
        rd(OFS_FSTAT, 8'h10);
        start_cycle();
        pins(6'h3c);
        wr(OFS_FACK, 8'h01);
        tick(1);
        check({4'h0, firq}, 8'h00);
        pins(6'h3c);
        start_cycle();
        pins(6'h3f);
        raise(2'd2, 8'hff);
        tick(6);
        pins(6'h0f);
        wr(OFS_FACK, 8'h04);
        start_cycle();
        pins(6'h3f);
        raise(2'd2, 8'h00);
        raise(2'd1, 8'hff);
        tick(6);
        pins(6'h3c);
        wr(OFS_FACK, 8'h02);
        start_cycle();
        pins(6'h3c);
        raise(2'd1, 8'h00);
        tick(4);
        start_cycle();
        pins(6'h3f);
        wr(OFS_FCTRL, 8'hf8);
        raise(2'd3, 8'hff);
        tick(6);
        pins(6'h0f);
        check({4'h0, firq}, 8'h08);
        wr(OFS_FCTRL, 8'hf0);
        tick(1);
        check({4'h0, firq}, 8'h00);
        rd(OFS_FSTAT, 8'h88);
        start_cycle();
        pins(6'h0f);
        raise(2'd3, 8'h00);
        pins(6'h0f);
        start_cycle();
        pins(6'h3f);
        rd(OFS_FSTAT, 8'h80);
        wr(OFS_FACK, 8'h08);
        wr(OFS_CTRL, 8'h1d);
        pins(6'h3c);
        rd(OFS_FSTAT, 8'h00);
        check({4'h0, firq}, 8'h00);
        wr(OFS_CTRL, 8'h0d);
        pins(6'h3c);
        start_cycle();
        pins(6'h3f);
        wr(OFS_DIRECT_OUTPUT_CTRL, 8'h7f);
        wr(OFS_CTRL, 8'h2d);
        pins(6'h0f);
        wr(OFS_CTRL, 8'h0d);
        pins(6'h3f);
        wr(OFS_CTRL, 8'h0c);
        pins(6'h3f);
        check({2'b00, oe_n}, 8'h00);
        check({7'h00, run}, 8'h00);
        check({7'h00, rirq}, 8'h01);
        raise(2'd0, 8'hff);
        tick(6);
        pins(6'h3c);
        raise(2'd0, 8'h00);
        wr(OFS_FACK, 8'h01);
        pins(6'h3f);
        wr(OFS_DIRECT_OUTPUT_CTRL, 8'h00);
        pins(6'h00);
        check({2'b00, oe_n}, 8'h3f);
        wr(OFS_POL, 8'h01);
        pins(6'h15);
        print_verdict();
    end
endmodule
`default_nettype wire
